// [src/rcw_pkg.sv]
// Package of constants for the runaway code watchdog
package rcw_pkg;
    localparam logic [15:0] CLEAR_PORT_ADDR = 16'hffff;
    localparam int PRESC_W = 12;
    localparam int CNT_W = 6;
    localparam int PRESC_KEEP_W = 4;
    localparam int RESET_HOLD_CYC = 32;
    localparam int POR_CLEAR_CYC = 4096;
    localparam logic DISABLE_RST = 1'b0;
    localparam logic RATE_SEL_RST = 1'b0;
    localparam logic [7:0] VEC_LOW_RST = 8'h00;
    localparam int CLK_PERIOD_NS = 50;
    localparam logic [3:0] LONG_TAP_CNT_BIT = 4'h5;
    localparam logic [3:0] SHORT_TAP_CNT_BIT = 4'h0;
endpackage : rcw_pkg

// [src/rcw_sync.sv]
// Two-stage synchroniser for pin levels
module rcw_sync #(
    parameter int W = 1
) (
    // Clock
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_r;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s1_r <= '0;
            q_o <= '0;
        end else if (ce_i) begin
            s1_r <= d_i;
            q_o <= s1_r;
        end
    end
endmodule : rcw_sync

// [src/rcw_watchdog.sv]
// Runaway code watchdog: prescaler, counter, clear port and reset pulse
module rcw_watchdog (
    // Clock and reset; clk_i is the oscillator clock
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Power-on and internal reset events
    input wire logic por_i,
    input wire logic int_rst_i,
    // CPU bus
    input wire logic [15:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wdata_i,
    input wire logic vec_fetch_i,
    input wire logic [7:0] vec_low_i,
    output logic [7:0] rdata_o,
    // Configuration write strobe and bits
    input wire logic cfg_wr_i,
    input wire logic cfg_disable_i,
    input wire logic cfg_rate_i,
    input wire logic cfg_stop_en_i,
    output logic watchdog_disable_o,
    output logic timeout_rate_select_o,
    // CPU modes
    input wire logic stop_exec_i,
    input wire logic stop_mode_i,
    input wire logic monitor_entry_i,
    input wire logic break_i,
    // Test voltage detectors from pins
    input wire logic irq_tst_i,
    input wire logic rst_tst_i,
    // Reset outputs
    output logic rst_pin_o,
    output logic rst_pin_oe_o,
    output logic cause_watchdog_o,
    output logic illegal_op_rst_o
);
    logic irq_tst_s;
    logic rst_tst_s;
    logic [rcw_pkg::PRESC_W-1:0] presc_r;
    logic [rcw_pkg::CNT_W-1:0] cnt_r;
    logic cfg_locked_r;
    logic mon_tst_r;
    logic mon_blank_r;
    logic [5:0] hold_r;
    logic [12:0] por_cnt_r;
    logic por_pend_r;
    logic active;
    logic presc_roll;
    logic overflow;
    logic clr_write;
    logic presc_full_clr;

    rcw_sync #(.W(2)) u_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .d_i({irq_tst_i, rst_tst_i}),
        .q_o({irq_tst_s, rst_tst_s})
    );

    // Configuration latches, write once after each reset
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || int_rst_i) begin
            watchdog_disable_o <= rcw_pkg::DISABLE_RST;
            timeout_rate_select_o <= rcw_pkg::RATE_SEL_RST;
            cfg_locked_r <= 1'b0;
        end else if (ce_i && cfg_wr_i && !cfg_locked_r) begin
            watchdog_disable_o <= cfg_disable_i;
            timeout_rate_select_o <= cfg_rate_i;
            cfg_locked_r <= 1'b1;
        end
    end

    // Monitor mode disable tracking; power-on pulse is frozen by ce_i too
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            mon_tst_r <= 1'b0;
            mon_blank_r <= 1'b0;
        end else if (ce_i) begin
            if (monitor_entry_i && irq_tst_s) begin
                mon_tst_r <= 1'b1;
            end else if (por_i || (!irq_tst_s && !rst_tst_s)) begin
                mon_tst_r <= 1'b0;
            end
            // Entry wins over a coincident power-on pulse
            if (monitor_entry_i && !irq_tst_s) begin
                mon_blank_r <= 1'b1;
            end else if (por_i) begin
                mon_blank_r <= 1'b0; // only power-on clears it
            end
        end
    end

    // Stop mode gates the clock; wait mode does not stop counting
    assign active = !watchdog_disable_o && !mon_tst_r && !mon_blank_r
        && !(break_i && rst_tst_s) && !stop_mode_i;
    assign clr_write = wr_i && (addr_i == rcw_pkg::CLEAR_PORT_ADDR);
    assign presc_full_clr = stop_exec_i || stop_mode_i || vec_fetch_i
        || (por_pend_r && por_cnt_r == 13'(rcw_pkg::POR_CLEAR_CYC - 1));

    // Timeout taps: short rate rolls the prescaler low 9 bits and counter bits 0..3, 16 steps -> 2^13
    // Long: full 12-bit prescaler rollover, counter 64 steps -> 2^18, minus kept low bits
    assign presc_roll = timeout_rate_select_o ? (presc_r[8:0] == 9'h1ff)
                                              : (presc_r == 12'hfff);
    assign overflow = active && presc_roll && (timeout_rate_select_o ?
        (cnt_r[3:0] == 4'hf) : (cnt_r == 6'h3f));

    // Power-on prescaler clear counter
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            por_cnt_r <= '0;
            por_pend_r <= 1'b0;
        end else if (ce_i) begin
            if (por_i) begin
                por_cnt_r <= '0;
                por_pend_r <= 1'b1;
            end else if (por_pend_r) begin
                if (por_cnt_r == 13'(rcw_pkg::POR_CLEAR_CYC - 1)) begin
                    por_pend_r <= 1'b0;
                end else begin
                    por_cnt_r <= por_cnt_r + 13'h1;
                end
            end
        end
    end

    // Prescaler
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || int_rst_i) begin
            presc_r <= '0;
        end else if (ce_i) begin
            if (presc_full_clr) begin
                presc_r <= '0;
            end else if (clr_write) begin
                presc_r <= {8'h00, presc_r[3:0]}; // stages 12..5 cleared
            end else if (active) begin
                presc_r <= presc_r + 12'h1;
            end
        end
    end

    // Counter
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || int_rst_i) begin
            cnt_r <= '0;
        end else if (ce_i) begin
            if (clr_write || overflow) begin
                cnt_r <= '0;
            end else if (active && presc_roll) begin
                cnt_r <= cnt_r + 6'h1;
            end
        end
    end

    // Reset pulse on the open-drain reset pin; no interrupt output exists
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            hold_r <= '0;
            rst_pin_o <= 1'b1;
            rst_pin_oe_o <= 1'b0;
        end else if (ce_i) begin
            if (overflow) begin
                hold_r <= 6'(rcw_pkg::RESET_HOLD_CYC - 1);
                rst_pin_o <= 1'b0;
                rst_pin_oe_o <= 1'b1;
            end else if (hold_r != 6'h00) begin
                hold_r <= hold_r - 6'h1;
            end else begin
                rst_pin_o <= 1'b1;
                rst_pin_oe_o <= 1'b0;
            end
        end
    end

    // Cause bit: set wins, cleared only by power-on
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cause_watchdog_o <= 1'b0;
        end else if (ce_i) begin
            if (overflow) begin
                cause_watchdog_o <= 1'b1;
            end else if (por_i) begin
                cause_watchdog_o <= 1'b0;
            end
        end
    end

    // Illegal opcode reset for disabled stop instruction
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            illegal_op_rst_o <= 1'b0;
        end else if (ce_i) begin
            illegal_op_rst_o <= stop_exec_i && !cfg_stop_en_i;
        end
    end

    // Read of the clear port returns vector low byte only
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_o <= rcw_pkg::VEC_LOW_RST;
        end else if (ce_i && rd_i && addr_i == rcw_pkg::CLEAR_PORT_ADDR) begin
            rdata_o <= vec_low_i;
        end
    end

    property p_pulse_len;
        @(posedge clk_i) disable iff (sys_rst_i)
        (overflow && ce_i) |=> (!rst_pin_o && rst_pin_oe_o);
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("reset pin not driven low");

    property p_cause;
        @(posedge clk_i) disable iff (sys_rst_i)
        (overflow && ce_i) |=> cause_watchdog_o;
    endproperty
    a_cause: assert property (p_cause) else $error("cause bit not set");

    property p_clear;
        @(posedge clk_i) disable iff (sys_rst_i || int_rst_i)
        (ce_i && clr_write && !presc_full_clr) |=> (cnt_r == 6'h00 && presc_r[11:4] == 8'h00);
    endproperty
    a_clear: assert property (p_clear) else $error("clear write failed");

    property p_stop_clr;
        @(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && stop_exec_i) |=> (presc_r == 12'h000);
    endproperty
    a_stop_clr: assert property (p_stop_clr) else $error("stop did not clear prescaler");

    property p_disabled;
        @(posedge clk_i) disable iff (sys_rst_i)
        (watchdog_disable_o || mon_blank_r) |-> !overflow;
    endproperty
    a_disabled: assert property (p_disabled) else $error("overflow while disabled");

    property p_read;
        @(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && rd_i && addr_i == rcw_pkg::CLEAR_PORT_ADDR) |=> (rdata_o == $past(vec_low_i));
    endproperty
    a_read: assert property (p_read) else $error("read not vector byte");

    property p_once;
        @(posedge clk_i) disable iff (sys_rst_i || int_rst_i)
        cfg_locked_r |=> $stable(watchdog_disable_o) && $stable(timeout_rate_select_o);
    endproperty
    a_once: assert property (p_once) else $error("config rewritten");

    property p_illegal;
        @(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && stop_exec_i && !cfg_stop_en_i) |=> illegal_op_rst_o;
    endproperty
    a_illegal: assert property (p_illegal) else $error("no illegal opcode reset");

    property p_vec;
        @(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && vec_fetch_i) |=> (presc_r == 12'h000);
    endproperty
    a_vec: assert property (p_vec) else $error("vector fetch kept prescaler");

    property p_por_clr;
        @(posedge clk_i) disable iff (sys_rst_i || int_rst_i)
        (ce_i && por_pend_r && !por_i && por_cnt_r == 13'(rcw_pkg::POR_CLEAR_CYC - 1))
            |=> (presc_r == 12'h000);
    endproperty
    a_por_clr: assert property (p_por_clr) else $error("power-on clear missed");

    property p_hold_low;
        @(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && !overflow && hold_r != 6'h00) |=> (!rst_pin_o && rst_pin_oe_o);
    endproperty
    a_hold_low: assert property (p_hold_low) else $error("reset pulse ended early");

    property p_hold_end;
        @(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && !overflow && hold_r == 6'h00) |=> (rst_pin_o && !rst_pin_oe_o);
    endproperty
    a_hold_end: assert property (p_hold_end) else $error("reset pulse too long");

    // Counter chain must freeze while a test voltage keeps the watchdog off
    property p_mon_quiet;
        @(posedge clk_i) disable iff (sys_rst_i || int_rst_i)
        (ce_i && mon_tst_r && !presc_full_clr && !clr_write)
            |=> ($stable(presc_r) && $stable(cnt_r));
    endproperty
    a_mon_quiet: assert property (p_mon_quiet) else $error("counting in monitor");

    property p_blank_quiet;
        @(posedge clk_i) disable iff (sys_rst_i || int_rst_i)
        (ce_i && mon_blank_r && !presc_full_clr && !clr_write)
            |=> ($stable(presc_r) && $stable(cnt_r));
    endproperty
    a_blank_quiet: assert property (p_blank_quiet) else $error("counting while blank");

    property p_break_quiet;
        @(posedge clk_i) disable iff (sys_rst_i || int_rst_i)
        (ce_i && break_i && rst_tst_s && !presc_full_clr && !clr_write)
            |=> ($stable(presc_r) && $stable(cnt_r));
    endproperty
    a_break_quiet: assert property (p_break_quiet) else $error("counting in break");

    property p_stop_mode;
        @(posedge clk_i) disable iff (sys_rst_i || int_rst_i)
        (ce_i && stop_mode_i && !clr_write) |=> (presc_r == 12'h000 && $stable(cnt_r));
    endproperty
    a_stop_mode: assert property (p_stop_mode) else $error("counting in stop mode");

    property p_int_rst;
        @(posedge clk_i) disable iff (sys_rst_i)
        int_rst_i |=> (presc_r == 12'h000 && cnt_r == 6'h00);
    endproperty
    a_int_rst: assert property (p_int_rst) else $error("internal reset kept state");

    property p_roll;
        @(posedge clk_i) disable iff (sys_rst_i || int_rst_i)
        (ce_i && active && presc_roll && !clr_write && !overflow)
            |=> (cnt_r == $past(cnt_r) + 6'h1);
    endproperty
    a_roll: assert property (p_roll) else $error("counter missed a rollover");

    c_overflow: cover property (@(posedge clk_i) disable iff (sys_rst_i) overflow);
    c_monitor: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        monitor_entry_i && irq_tst_s);
    c_por_clr: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        por_pend_r && por_cnt_r == 13'(rcw_pkg::POR_CLEAR_CYC - 1));
    c_clear: cover property (@(posedge clk_i) disable iff (sys_rst_i) clr_write);
    c_short: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        timeout_rate_select_o && overflow);
endmodule : rcw_watchdog

// [verification/rcw_cpu_model.sv]
// CPU core model driving the watchdog's memory bus
module rcw_cpu_model (
    // Clock and reset pin view
    input wire logic clk_i,
    input wire logic rst_oe_i,
    // Bus towards the watchdog
    output logic [15:0] addr_o,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] wdata_o,
    output logic int_rst_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic pulse_r;
    initial begin
        addr_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
        pulse_r = 1'b0;
    end
    // A pulled reset pin holds the whole core in reset
    assign int_rst_o = rst_oe_i | pulse_r;
    task automatic bus_op(input logic [15:0] a, input logic w, input logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = w;
        rd_o = !w;
        @(negedge clk_i);
        wr_o = 1'b0;
        rd_o = 1'b0;
        // Released bus shows no stale value
        addr_o = ~a;
        wdata_o = ~d;
    endtask : bus_op
    task automatic pulse_reset();
        @(negedge clk_i);
        pulse_r = 1'b1;
        @(negedge clk_i);
        pulse_r = 1'b0;
    endtask : pulse_reset
endmodule : rcw_cpu_model

// [verification/tb.sv]
// Testbench for the runaway code watchdog
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic por_i = 1'b0;
    logic [7:0] vec_low_i = 8'h5a;
    logic cfg_wr_i = 1'b0;
    logic cfg_disable_i = 1'b0;
    logic cfg_rate_i = 1'b0;
    logic cfg_stop_en_i = 1'b1;
    logic stop_exec_i = 1'b0;
    logic break_i = 1'b0;
    logic rst_tst_i = 1'b0;
    logic vec_fetch_i = 1'b0;
    logic stop_mode_i = 1'b0;
    logic monitor_entry_i = 1'b0;
    logic irq_tst_i = 1'b0;
    logic [15:0] addr_i;
    logic [7:0] wdata_i;
    logic [7:0] rdata_o;
    logic wr_i, rd_i, int_rst_i, watchdog_disable_o, timeout_rate_select_o;
    logic rst_pin_o, rst_pin_oe_o, cause_watchdog_o, illegal_op_rst_o;
    int miscompares = 0;
    int n_tests = 0;
    int n;
    rcw_watchdog dut_u (.clk_i, .sys_rst_i, .ce_i(1'b1), .por_i, .int_rst_i, .addr_i,
        .wr_i, .rd_i, .wdata_i, .vec_fetch_i, .vec_low_i, .rdata_o, .cfg_wr_i,
        .cfg_disable_i, .cfg_rate_i, .cfg_stop_en_i, .watchdog_disable_o,
        .timeout_rate_select_o, .stop_exec_i, .stop_mode_i,
        .monitor_entry_i, .break_i, .irq_tst_i, .rst_tst_i, .rst_pin_o,
        .rst_pin_oe_o, .cause_watchdog_o, .illegal_op_rst_o);
    rcw_cpu_model cpu_u (.clk_i, .rst_oe_i(rst_pin_oe_o), .addr_o(addr_i), .wr_o(wr_i),
        .rd_o(rd_i), .wdata_o(wdata_i), .int_rst_o(int_rst_i));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    task automatic cfg(input logic dis, input logic rate);
        @(negedge clk_i);
        cfg_disable_i = dis;
        cfg_rate_i = rate;
        cfg_wr_i = 1'b1;
        @(negedge clk_i);
        cfg_wr_i = 1'b0;
        cfg_disable_i = ~dis;
        cfg_rate_i = ~rate;
    endtask : cfg
    // Cycles until the reset pin is pulled, capped at lim
    task automatic wait_rst(input int lim, output int cyc);
        cyc = 0;
        while (rst_pin_oe_o !== 1'b1 && cyc < lim) begin
            @(negedge clk_i);
            cyc++;
        end
    endtask : wait_rst
    task automatic stop_try(input logic en, input logic [15:0] exp);
        int k;
        k = 0;
        cfg_stop_en_i = en;
        @(negedge clk_i);
        stop_exec_i = 1'b1;
        repeat (3) begin
            @(negedge clk_i);
            stop_exec_i = 1'b0;
            k += int'(illegal_op_rst_o === 1'b1);
        end
        chk("illegal_op_pulses", exp, 16'(k));
    endtask : stop_try
    initial begin
        repeat (20) @(negedge clk_i);
        sys_rst_i = 1'b0;
        chk("rst_pin", 16'h0001, {15'h0000, rst_pin_o});
        chk("rst_oe", 16'h0000, {15'h0000, rst_pin_oe_o});
        chk("disable_rst", 16'h0000, {15'h0000, watchdog_disable_o});
        chk("rate_rst", 16'h0000, {15'h0000, timeout_rate_select_o});
        cfg(1'b0, 1'b1);
        cfg(1'b1, 1'b0);
        chk("rate_cfg", 16'h0001, {15'h0000, timeout_rate_select_o});
        chk("disable_once", 16'h0000, {15'h0000, watchdog_disable_o});
        vec_low_i = 8'hc3;
        cpu_u.bus_op(16'hffff, 1'b0, 8'h00);
        chk("clear_port_read", 16'h00c3, {8'h00, rdata_o});
        cpu_u.bus_op(16'hffff, 1'b1, 8'h3c);
        wait_rst(9000, n);
        chk("short_timeout", 16'h0001, 16'(n >= 8170 && n <= 8200));
        if (n >= 9000) begin
            end_sim();
        end
        n = 0;
        while (rst_pin_oe_o === 1'b1 && rst_pin_o === 1'b0 && n < 100) begin
            @(negedge clk_i);
            n++;
        end
        chk("rst_low_cycles", 16'd32, 16'(n));
        chk("cause_set", 16'h0001, {15'h0000, cause_watchdog_o});
        chk("rate_cleared", 16'h0000, {15'h0000, timeout_rate_select_o});
        cfg(1'b0, 1'b1);
        break_i = 1'b1;
        rst_tst_i = 1'b1;
        wait_rst(9000, n);
        chk("break_quiet", 16'd9000, 16'(n));
        break_i = 1'b0;
        rst_tst_i = 1'b0;
        repeat (3) begin
            cpu_u.bus_op(16'hffff, 1'b1, 8'h00);
            wait_rst(6000, n);
            chk("refresh_quiet", 16'd6000, 16'(n));
        end
        cpu_u.pulse_reset();
        chk("cause_sticky", 16'h0001, {15'h0000, cause_watchdog_o});
        cfg(1'b1, 1'b1);
        chk("disable_set", 16'h0001, {15'h0000, watchdog_disable_o});
        wait_rst(9000, n);
        chk("disabled_quiet", 16'd9000, 16'(n));
        stop_try(1'b0, 16'h0001);
        stop_try(1'b1, 16'h0000);
        cpu_u.pulse_reset();
        cfg(1'b0, 1'b1);
        @(negedge clk_i);
        vec_fetch_i = 1'b1;
        @(negedge clk_i);
        vec_fetch_i = 1'b0;
        stop_mode_i = 1'b1;
        wait_rst(9000, n);
        chk("stop_mode_quiet", 16'd9000, 16'(n));
        stop_mode_i = 1'b0;
        irq_tst_i = 1'b1;
        repeat (3) @(negedge clk_i);
        monitor_entry_i = 1'b1;
        @(negedge clk_i);
        monitor_entry_i = 1'b0;
        wait_rst(9000, n);
        chk("monitor_quiet", 16'd9000, 16'(n));
        irq_tst_i = 1'b0;
        wait_rst(9000, n);
        chk("monitor_release", 16'h0001, 16'(n >= 8170 && n <= 8200));
        repeat (40) @(negedge clk_i);
        monitor_entry_i = 1'b1;
        @(negedge clk_i);
        monitor_entry_i = 1'b0;
        cpu_u.pulse_reset();
        cfg(1'b0, 1'b1);
        wait_rst(9000, n);
        chk("blank_quiet", 16'd9000, 16'(n));
        @(negedge clk_i);
        por_i = 1'b1;
        @(negedge clk_i);
        por_i = 1'b0;
        @(negedge clk_i);
        chk("cause_por", 16'h0000, {15'h0000, cause_watchdog_o});
        wait_rst(9000, n);
        chk("por_rearm", 16'h0001, 16'(n >= 8170 && n <= 8200));
        end_sim();
    end
endmodule : tb
